//--- core/wdt_osc_counter.sv
// Purpose: time-out counter running on sampled slow-oscillator ticks
// Assumes: tick is a one-cycle pulse per oscillator period
// Notes:   count at or past the limit minus one expires on the next tick
`timescale 1ns/1ns
module wdt_osc_counter
    import wdt_pkg::*;
#(
    parameter logic [CNT_W-1:0] BASE_CYCLES = CNT_W'(BASE_OSC_CYC)
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic       tick,
    input  wire logic       restart,
    input  wire logic       run,
    input  wire logic [3:0] sel,
    // result
    output logic            expire_q
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] limit;

    assign limit = BASE_CYCLES << sel;

    // shorter period chosen mid-count: a count already past expires next tick
    always_ff @(posedge aclk) begin
        if (!aresetn || restart || !run) begin
            cnt_q    <= '0;
            expire_q <= 1'b0;
        end else if (tick) begin
            if (cnt_q >= limit - CNT_W'(1)) begin
                cnt_q    <= '0;
                expire_q <= 1'b1;
            end else begin
                cnt_q    <= cnt_q + CNT_W'(1);
                expire_q <= 1'b0;
            end
        end else begin
            expire_q <= 1'b0;
        end
    end

endmodule : wdt_osc_counter

//--- core/wdt_reset_status.sv
// Purpose: watchdog control and reset-cause status behind AXI4-Lite
// Assumes: aresetn is the power-on reset; other reset sources are pulses
// Notes:   oscillator input sampled on aclk, rising edge is one tick
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module wdt_reset_status
    import wdt_pkg::*;
#(
    parameter logic [CNT_W-1:0] BASE_CYCLES = CNT_W'(BASE_OSC_CYC)
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    // axi4-lite write data
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    // axi4-lite write response
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    // axi4-lite read address
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    // axi4-lite read data
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    // cpu side
    input  wire logic              cpu_gie,
    input  wire logic              irq_taken,
    input  wire logic              wdr_restart,
    output logic                   timeout_irq_req,
    // reset sources and fuse
    input  wire logic              always_on_fuse,
    input  wire logic              brownout_event,
    input  wire logic              pin_reset_event,
    input  wire logic              wd_osc,
    output logic                   wd_system_reset
);

    // =====================================================================
    // bus write side
    logic              aw_held_q;
    logic              w_held_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [7:0]        wdata_q;
    logic              wstrb0_q;
    logic              do_write;
    logic              wr_ctrl;
    logic              wr_stat;

    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_ctrl  = do_write && wstrb0_q && (waddr_q == OFF_CTRL);
    assign wr_stat  = do_write && wstrb0_q && (waddr_q == OFF_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            waddr_q       <= '0;
            wdata_q       <= 8'h00;
            wstrb0_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q     <= 1'b1;
                waddr_q       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_held_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q     <= 1'b1;
                wdata_q      <= s_axi_wdata[7:0];
                wstrb0_q     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (!w_held_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (do_write) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (waddr_q == OFF_CTRL || waddr_q == OFF_STATUS) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // =====================================================================
    // watchdog state
    logic       wd_reset_seen_flag_q;
    logic       brownout_seen_flag_q;
    logic       pin_reset_seen_flag_q;
    logic       powerup_seen_flag_q;
    logic       timeout_irq_flag_q;
    logic       timeout_irq_enable_q;
    logic       timeout_reset_enable_q;
    logic [3:0] sel_q;
    logic [2:0] unlock_cnt_q;
    logic       osc_q;
    logic       tick;
    logic       expire;
    logic       fire;
    logic       set_irq_flag;
    logic       int_reset;
    logic       unlock_open;
    logic       unlock_start;
    logic       rst_en_eff;
    logic       irq_en_eff;
    logic [3:0] wsel;
    logic [3:0] st_clr;
    wd_mode_t   mode;

    assign unlock_open  = (unlock_cnt_q != 3'h0);
    assign unlock_start = wr_ctrl && wdata_q[CT_UNLOCK] && wdata_q[CT_RST_EN];
    assign rst_en_eff   = timeout_reset_enable_q || wd_reset_seen_flag_q || always_on_fuse;
    assign irq_en_eff   = timeout_irq_enable_q && !always_on_fuse;
    assign st_clr       = {4{wr_stat}} & ~wdata_q[3:0];
    assign wsel         = {wdata_q[CT_SEL3], wdata_q[2:0]};
    assign int_reset    = wd_system_reset || brownout_event || pin_reset_event;
    assign tick         = wd_osc && !osc_q;

    always_comb begin
        if (always_on_fuse) begin
            mode = MODE_RST;
        end else begin
            mode = wd_mode_t'({rst_en_eff, timeout_irq_enable_q});
        end
    end

    // time-out action per mode
    always_comb begin
        fire         = 1'b0;
        set_irq_flag = 1'b0;
        if (expire) begin
            case (mode)
                MODE_IRQ: begin
                    set_irq_flag = 1'b1;
                end
                MODE_RST: begin
                    fire = 1'b1;
                end
                MODE_BOTH: begin
                    if (timeout_irq_flag_q) begin
                        fire = 1'b1;
                    end else begin
                        set_irq_flag = 1'b1;
                    end
                end
                default: begin
                    fire = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= wd_osc;
        end
    end

    wdt_osc_counter #(
        .BASE_CYCLES (BASE_CYCLES)
    ) u_counter (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .tick     (tick),
        .restart  (wdr_restart || int_reset),
        .run      (mode != MODE_STOP),
        .sel      (sel_q),
        .expire_q (expire)
    );

    // =====================================================================
    // reset-cause flags: hardware set wins over a written zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_reset_seen_flag_q  <= 1'b0;
            brownout_seen_flag_q  <= 1'b0;
            pin_reset_seen_flag_q <= 1'b0;
            powerup_seen_flag_q   <= 1'b1;
        end else begin
            wd_reset_seen_flag_q  <= fire || (wd_reset_seen_flag_q && !st_clr[ST_WD_SEEN]);
            brownout_seen_flag_q  <= brownout_event || (brownout_seen_flag_q && !st_clr[ST_BROWNOUT]);
            pin_reset_seen_flag_q <= pin_reset_event || (pin_reset_seen_flag_q && !st_clr[ST_PIN_RESET]);
            powerup_seen_flag_q   <= powerup_seen_flag_q && !st_clr[ST_POWERUP];
        end
    end

    // =====================================================================
    // control register
    always_ff @(posedge aclk) begin
        if (!aresetn || int_reset) begin
            unlock_cnt_q <= 3'h0;
        end else if (unlock_start) begin
            unlock_cnt_q <= UNLOCK_CYCLES;
        end else if (wr_ctrl && unlock_open) begin
            unlock_cnt_q <= 3'h0;
        end else if (unlock_open) begin
            unlock_cnt_q <= unlock_cnt_q - 3'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || int_reset) begin
            timeout_reset_enable_q <= CTRL_RESET[CT_RST_EN];
            sel_q                  <= {CTRL_RESET[CT_SEL3], CTRL_RESET[2:0]};
        end else if (wr_ctrl && unlock_open && !wdata_q[CT_UNLOCK]) begin
            timeout_reset_enable_q <= wdata_q[CT_RST_EN] || wd_reset_seen_flag_q;
            sel_q                  <= wsel;
        end else if (wr_ctrl) begin
            timeout_reset_enable_q <= timeout_reset_enable_q || wdata_q[CT_RST_EN] || wd_reset_seen_flag_q;
            sel_q                  <= sel_q | wsel;
        end else if (wd_reset_seen_flag_q) begin
            timeout_reset_enable_q <= 1'b1;
        end
    end

    // vector clears only the flag in irq mode, both bits in combined mode
    always_ff @(posedge aclk) begin
        if (!aresetn || int_reset) begin
            timeout_irq_enable_q <= CTRL_RESET[CT_IRQ_EN];
            timeout_irq_flag_q   <= CTRL_RESET[CT_IRQ_FLAG];
        end else begin
            if (irq_taken && mode == MODE_BOTH) begin
                timeout_irq_enable_q <= 1'b0;
            end else if (wr_ctrl) begin
                timeout_irq_enable_q <= wdata_q[CT_IRQ_EN];
            end
            if (set_irq_flag) begin
                timeout_irq_flag_q <= 1'b1;
            end else if (irq_taken || (wr_ctrl && wdata_q[CT_IRQ_FLAG])) begin
                timeout_irq_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timeout_irq_req <= 1'b0;
            wd_system_reset <= 1'b0;
        end else begin
            timeout_irq_req <= timeout_irq_flag_q && irq_en_eff && cpu_gie;
            wd_system_reset <= fire;
        end
    end

    // =====================================================================
    // bus read side
    logic [7:0] ctrl_view;

    assign ctrl_view = {timeout_irq_flag_q, irq_en_eff, sel_q[3], unlock_open, rst_en_eff, sel_q[2:0]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            if (s_axi_araddr == OFF_STATUS) begin
                s_axi_rdata <= {28'h0000000, wd_reset_seen_flag_q, brownout_seen_flag_q,
                                pin_reset_seen_flag_q, powerup_seen_flag_q};
                s_axi_rresp <= RESP_OKAY;
            end else if (s_axi_araddr == OFF_CTRL) begin
                s_axi_rdata <= {24'h000000, ctrl_view};
                s_axi_rresp <= RESP_OKAY;
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence unlock_begin_s;
        unlock_start && !int_reset;
    endsequence

    sequence unlock_quiet_s;
        (!wr_ctrl && !int_reset)[*4];
    endsequence

    a_unlock_opens: assert property (unlock_begin_s |=> unlock_open)
        else $error("unlock bit not set after unlock write");
    a_unlock_expires: assert property (unlock_begin_s ##1 unlock_quiet_s |=> !unlock_open)
        else $error("unlock window outlived four cycles");
    a_locked_rst_en: assert property (wr_ctrl && !unlock_open && timeout_reset_enable_q && !int_reset
        |=> timeout_reset_enable_q)
        else $error("reset enable cleared outside window");
    a_seen_holds_en: assert property (wd_reset_seen_flag_q && !int_reset |=> timeout_reset_enable_q)
        else $error("reset enable dropped with watchdog flag set");
    a_irq_gated: assert property (timeout_irq_req |-> $past(timeout_irq_flag_q && irq_en_eff && cpu_gie))
        else $error("irq request without both enables");
    a_reset_pulse: assert property (wd_system_reset |-> wd_reset_seen_flag_q ##1 !wd_system_reset)
        else $error("reset pulse not single or flag not set");
    a_fuse_resets: assert property (always_on_fuse && expire |=> wd_system_reset)
        else $error("fuse time-out gave no reset");
    a_combined_ack: assert property (irq_taken && mode == MODE_BOTH && !expire && !int_reset
        |=> !timeout_irq_enable_q && !timeout_irq_flag_q)
        else $error("vector did not clear enable and flag");
    a_second_timeout: assert property (expire && mode == MODE_BOTH && timeout_irq_flag_q |=> wd_system_reset)
        else $error("unserviced time-out gave no reset");
    a_seen_cleared: assert property (st_clr[ST_WD_SEEN] && !fire |=> !wd_reset_seen_flag_q)
        else $error("watchdog flag survived written zero");
    a_por_flag: assert property ($rose(aresetn) |-> powerup_seen_flag_q)
        else $error("power-on flag not set after reset");

endmodule : wdt_reset_status

//--- shared/wdt_pkg.sv
// Purpose: shared constants for the watchdog and reset-cause block
// Assumes: AXI4-Lite, 32-bit data, byte addresses, one clock
// Notes:   offsets are byte addresses of one aligned word each
package wdt_pkg;

    // =====================================================================
    // bus
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    localparam logic [11:0] OFF_STATUS    = 12'h034;
    localparam logic [11:0] OFF_CTRL      = 12'h060;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // =====================================================================
    // reset_cause_status fields
    localparam int          ST_WD_SEEN    = 3;
    localparam int          ST_BROWNOUT   = 2;
    localparam int          ST_PIN_RESET  = 1;
    localparam int          ST_POWERUP    = 0;

    // =====================================================================
    // watchdog_control fields
    localparam int          CT_IRQ_FLAG   = 7;
    localparam int          CT_IRQ_EN     = 6;
    localparam int          CT_SEL3       = 5;
    localparam int          CT_UNLOCK     = 4;
    localparam int          CT_RST_EN     = 3;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;

    // =====================================================================
    // timing
    localparam logic [2:0]  UNLOCK_CYCLES = 3'h4;
    localparam int          CNT_W         = 27;
    localparam int          BASE_OSC_CYC  = 2048;

    typedef enum logic [1:0] {
        MODE_STOP = 2'b00,
        MODE_IRQ  = 2'b01,
        MODE_RST  = 2'b10,
        MODE_BOTH = 2'b11
    } wd_mode_t;

endpackage : wdt_pkg

//--- tb/wdt_reset_status_tb.sv
// Purpose: self-checking bench for the watchdog and reset-cause block
// Assumes: BASE_CYCLES shrunk to 4; one oscillator tick per four aclk cycles
// Notes:   bready and rready stay high, so every answer is taken at once
`timescale 1ns/1ns
module wdt_reset_status_tb;
    import wdt_pkg::*;

    localparam logic [CNT_W-1:0] BASE = 27'h4;

    // ========================================
    // signals
    logic              aclk            = 1'b0;
    logic              aresetn         = 1'b0;
    logic              s_axi_awvalid   = 1'b0;
    logic              s_axi_wvalid    = 1'b0;
    logic              s_axi_arvalid   = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr    = 12'h000;
    logic [ADDR_W-1:0] s_axi_araddr    = 12'h000;
    logic [DATA_W-1:0] s_axi_wdata     = 32'h0;
    logic              cpu_gie         = 1'b0;
    logic              irq_taken       = 1'b0;
    logic              wdr_restart     = 1'b0;
    logic              always_on_fuse  = 1'b0;
    logic              brownout_event  = 1'b0;
    logic              pin_reset_event = 1'b0;
    logic              wd_osc          = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [DATA_W-1:0] s_axi_rdata;
    logic              timeout_irq_req, wd_system_reset;
    logic              rst_prev        = 1'b0;
    logic [31:0]       seed            = 32'h0000000B;
    logic [31:0]       d;
    logic [1:0]        r;
    logic              m_flag, m_ie, m_re, m_win;
    logic [3:0]        m_sel, m_st;
    int                n_errors        = 0;
    int                checks_done     = 0;
    int                rst_cnt         = 0;
    int                cyc             = 0;
    int                n;

    wdt_reset_status #(.BASE_CYCLES(BASE)) uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .cpu_gie(cpu_gie), .irq_taken(irq_taken), .wdr_restart(wdr_restart),
        .timeout_irq_req(timeout_irq_req), .always_on_fuse(always_on_fuse),
        .brownout_event(brownout_event), .pin_reset_event(pin_reset_event), .wd_osc(wd_osc),
        .wd_system_reset(wd_system_reset)
    );

    always #2 aclk = ~aclk;

    // ========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // readback shows effective reset enable; unlock bit is never read inside its window
    function automatic logic [31:0] exp_ctl();
        return {24'h0, m_flag, m_ie & ~always_on_fuse, m_sel[3], 1'b0,
                m_re | m_st[3] | always_on_fuse, m_sel[2:0]};
    endfunction : exp_ctl

    task automatic m_clr();
        m_flag = 1'b0;
        m_ie   = 1'b0;
        m_re   = 1'b0;
        m_win  = 1'b0;
        m_sel  = 4'h0;
    endtask : m_clr

    task automatic tally_and_finish();
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic aw;
        logic w;
        aw = 1'b1;
        w  = 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (!aw && !w && s_axi_bvalid === 1'b1) begin
                resp = s_axi_bresp;
                break;
            end
            if (aw && s_axi_awready === 1'b1) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        v    = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : rd

    // control write: model keeps the unlock window and the set-only rule
    task automatic wc(input logic [7:0] v);
        wr(OFF_CTRL, {24'h0, v}, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        if (v[7]) m_flag = 1'b0;
        m_ie = v[6];
        if (m_win && !v[4]) begin
            m_re  = v[3] | m_st[3];
            m_sel = {v[5], v[2:0]};
        end else begin
            m_re  = m_re | v[3];
            m_sel = m_sel | {v[5], v[2:0]};
        end
        m_win = v[4] & v[3];
    endtask : wc

    task automatic ws(input logic [31:0] v);
        wr(OFF_STATUS, v, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        m_st = m_st & v[3:0];
    endtask : ws

    task automatic rc();
        rd(OFF_CTRL, d, r);
        chk(d, exp_ctl());
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask : rc

    task automatic rs();
        rd(OFF_STATUS, d, r);
        chk(d, {28'h0, m_st});
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask : rs

    task automatic ev(input int k);
        brownout_event  <= (k == 0);
        pin_reset_event <= (k == 1);
        irq_taken       <= (k == 2);
        wdr_restart     <= (k == 3);
        @(posedge aclk);
        brownout_event  <= 1'b0;
        pin_reset_event <= 1'b0;
        irq_taken       <= 1'b0;
        wdr_restart     <= 1'b0;
        @(posedge aclk);
        if (k < 2) begin
            m_st = m_st | (k == 0 ? 4'h4 : 4'h2);
            m_clr();
        end
    endtask : ev

    task automatic osc_tick(input int k);
        repeat (k) begin
            wd_osc <= 1'b1;
            repeat (2) @(posedge aclk);
            wd_osc <= 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask : osc_tick

    task automatic to_reset(input logic [3:0] c);
        int n0;
        n0 = rst_cnt;
        ev(3);
        wc({2'b00, c[3], 1'b0, 1'b1, c[2:0]});
        ev(3);
        osc_tick(int'(BASE << c) - 1);
        chk(rst_cnt, n0);
        osc_tick(1);
        chk(rst_cnt, n0 + 1);
        m_st = m_st | 4'h8;
        m_clr();
        rs();
        rc();
    endtask : to_reset

    // ========================================
    // monitors
    always @(posedge aclk) begin
        cyc     <= cyc + 1;
        rst_prev <= wd_system_reset;
        if (wd_system_reset === 1'b1) rst_cnt <= rst_cnt + 1;
        if (wd_system_reset === 1'b1 && rst_prev === 1'b1) chk(32'h1, 32'h0);
        if (cyc == 30000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ========================================
    // sequence
    initial begin
        m_st = 4'h1;
        m_clr();
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rs();
        rc();
        rd(12'h100, d, r);
        chk({d[29:0], r}, {30'h0, RESP_SLVERR});
        wr(12'h100, rnd(), r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        ws(32'h0);
        rs();
        ev(0);
        rs();
        ev(1);
        rs();
        ws(rnd());
        rs();
        ws(32'h0);
        n = rst_cnt;
        osc_tick(4);
        rc();
        chk(rst_cnt, n);
        wc(8'h40);
        ev(3);
        osc_tick(4);
        m_flag = 1'b1;
        rc();
        chk({31'h0, timeout_irq_req}, 32'h0);
        cpu_gie <= 1'b1;
        repeat (3) @(posedge aclk);
        chk({31'h0, timeout_irq_req}, 32'h1);
        wc(8'hC0);
        rc();
        chk({31'h0, timeout_irq_req}, 32'h0);
        ev(3);
        osc_tick(4);
        m_flag = 1'b1;
        ev(2);
        m_flag = 1'b0;
        rc();
        cpu_gie <= 1'b0;
        wc(8'h00);
        wc(8'h08);
        wc(8'h00);
        rc();
        wc(8'h18);
        wc(8'h01);
        rc();
        wc(8'h00);
        rc();
        wc(8'h18);
        repeat (8) @(posedge aclk);
        m_win = 1'b0;
        wc(8'h00);
        rc();
        wc(8'h18);
        wc(8'h00);
        rc();
        n = rst_cnt;
        wc(8'h48);
        ev(3);
        osc_tick(4);
        m_flag = 1'b1;
        rc();
        ev(2);
        m_flag = 1'b0;
        m_ie   = 1'b0;
        rc();
        wc(8'h48);
        ev(3);
        osc_tick(4);
        chk(rst_cnt, n);
        osc_tick(4);
        chk(rst_cnt, n + 1);
        m_st = m_st | 4'h8;
        m_clr();
        rs();
        wc(8'h18);
        wc(8'h00);
        rc();
        ws(rnd() & 32'hFFFFFFF7);
        wc(8'h18);
        wc(8'h00);
        rc();
        for (int i = 0; i < 4; i++) begin
            d = rnd();
            to_reset(i == 3 ? 4'h8 : {2'b00, d[1:0]});
        end
        always_on_fuse <= 1'b1;
        @(posedge aclk);
        wc(8'h40);
        rc();
        n = rst_cnt;
        ev(3);
        osc_tick(4);
        chk(rst_cnt, n + 1);
        m_st = m_st | 4'h8;
        m_clr();
        always_on_fuse <= 1'b0;
        ev(0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        m_st = 4'h1;
        m_clr();
        rs();
        rc();
        tally_and_finish();
    end

endmodule : wdt_reset_status_tb
